// ==== rtl/pro_pkg.sv ====
// shared constants and carriers for the polygon raster option stage
package pro_pkg;
   // ==========================================================
   // register map (byte addresses, avalon word aligned)
   localparam logic [4:0] REG_CTRL = 5'h00;
   localparam logic [4:0] REG_FACTOR = 5'h04;
   localparam logic [4:0] REG_UNITS = 5'h08;
   localparam logic [4:0] REG_MRD = 5'h0C;
   localparam logic [4:0] REG_OCC = 5'h10;
   localparam logic [4:0] REG_FRAGS = 5'h14;
   // ==========================================================
   // control register fields
   localparam int CTL_AA = 0;
   localparam int CTL_MODE = 1;
   localparam int CTL_OFS_PT = 3;
   localparam int CTL_OFS_LN = 4;
   localparam int CTL_OFS_FL = 5;
   localparam int CTL_CULL = 6;
   localparam int CTL_CSEL = 7;
   localparam int CTL_MS = 9;
   localparam int CTL_SBUF = 10;
   localparam int CTL_EARLY = 11;
   localparam int CTL_ZFLT = 12;
   localparam int CTL_ZPRES = 13;
   localparam int CTL_PT_AA = 14;
   localparam int CTL_LN_AA = 15;
   localparam int CTL_BITS = 16;
   // ==========================================================
   // encodings and reset values
   localparam logic [1:0] MODE_POINT = 2'h0;
   localparam logic [1:0] MODE_LINE = 2'h1;
   localparam logic [1:0] MODE_FILL = 2'h2;
   localparam logic [1:0] CSEL_FRONT = 2'h0;
   localparam logic [1:0] CSEL_BACK = 2'h1;
   localparam logic [1:0] CSEL_BOTH = 2'h2;
   localparam logic [15:0] CTRL_RESET = 16'h2284;
   localparam logic [31:0] FACTOR_RESET = 32'h0;
   localparam logic [31:0] UNITS_RESET = 32'h0;
   localparam logic [31:0] MRD_RESET = 32'h00000001;
   // ==========================================================
   // number formats: depth and slopes are q16.16, one = 0x10000
   localparam logic [31:0] Z_ONE = 32'h00010000;
   localparam int FRAC_BITS = 16;
   localparam logic signed [8:0] MANT_BITS = 9'sh017;
   localparam logic [7:0] COV_FULL = 8'hFF;
   localparam int NSAMP = 4;
   // ==========================================================
   typedef struct packed {
      logic [31:0] xy;
      logic front;
      logic [31:0] z;
      logic [31:0] z_area;
      logic signed [31:0] dzdx;
      logic signed [31:0] dzdy;
      logic signed [7:0] zexp;
      logic [NSAMP-1:0] samples;
      logic center_in;
      logic [7:0] area_cov;
      logic owned;
      logic scissor_ok;
      logic stencil_ok;
      logic depth_ok;
   } pro_frag_in_s;
   typedef struct packed {
      logic [31:0] xy;
      logic [31:0] z;
      logic [NSAMP-1:0] cov_mask;
      logic [7:0] cov_val;
      logic early_done;
      logic shader_z_ignored;
   } pro_frag_out_s;
endpackage : pro_pkg

// ==== rtl/pro_raster_top.sv ====
// polygon raster options, depth offset and early fragment tests
// ==========================================================
// What this block does
// - antialias: emit overlapped squares with coverage
// - antialias attributes area averaged, centre if full
// - point, line or fill rasterization per mode
// - mode applied only after clip and cull
// - polygon antialias only in fill mode
// - offset = slope*factor + resolution*units
// - slope is max of absolute partials
// - resolution fixed, or 2^(e-n) for float
// - fixed depth works in unit range
// - per-mode offset enables gate the addition
// - clamp offset depth to unit range
// - multisample: any covered sample emits fragment
// - culled polygon yields no fragments
// - coverage bit set iff sample covered
// - sample attributes, shared evaluation allowed
// - multisample polygon method only in fill; here the sample mask is used in every mode
// - reset: no aa, fill, zero offset, disabled
// - ownership, scissor, stencil, depth, count order
// - stencil/depth/count early only when enabled
// - discarded fragments never forwarded
// - early mode ignores shader depth
// - cull selection decides front/back rasterization
//
// Design decisions made here: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
module pro_raster_top
   import pro_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic in_valid,
   output logic in_ready,
   input wire pro_frag_in_s in_frag,
   output logic out_valid,
   input wire logic out_ready,
   output pro_frag_out_s out_frag
);
   // ==========================================================
   // helpers
   function automatic logic [31:0] merge_be(input logic [31:0] old,
      input logic [31:0] wd, input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return r;
   endfunction : merge_be

   function automatic logic [31:0] abs32(input logic signed [31:0] v);
      return v[31] ? 32'(-v) : 32'(v);
   endfunction : abs32

   function automatic logic [2:0] popcnt(input logic [NSAMP-1:0] v);
      logic [2:0] c;
      c = 3'h0;
      for (int i = 0; i < NSAMP; i++) begin
         c = c + 3'(v[i]);
      end
      return c;
   endfunction : popcnt

   // 2^(e-n) in q16.16; underflow gives zero, overflow saturates
   function automatic logic [31:0] pow2_res(input logic signed [7:0] e);
      logic signed [9:0] s;
      s = 10'(e) - 10'(MANT_BITS) + 10'(FRAC_BITS);
      if (s < 0) begin
         return 32'h0;
      end
      if (s > 10'sd30) begin
         return 32'h40000000;
      end
      return 32'h1 << s[4:0];
   endfunction : pow2_res

   // ==========================================================
   // register file
   logic [CTL_BITS-1:0] ctrl;
   logic [31:0] factor;
   logic [31:0] units;
   logic [31:0] mrd;
   logic [31:0] occ_count;
   logic [31:0] frag_count;
   logic bus_req;
   logic bus_take;
   assign bus_req = avs_read | avs_write;
   // request answered on the second edge it is seen
   assign bus_take = bus_req & ~avs_waitrequest;

   always_ff @(posedge clock) begin
      if (rst) begin
         avs_waitrequest <= 1'b1;
      end else if (bus_req && avs_waitrequest) begin
         avs_waitrequest <= 1'b0;
      end else begin
         avs_waitrequest <= 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         avs_readdata <= 32'h0;
      end else if (avs_read && avs_waitrequest) begin
         unique case (avs_address)
            REG_CTRL: avs_readdata <= {16'h0, ctrl};
            REG_FACTOR: avs_readdata <= factor;
            REG_UNITS: avs_readdata <= units;
            REG_MRD: avs_readdata <= mrd;
            REG_OCC: avs_readdata <= occ_count;
            REG_FRAGS: avs_readdata <= frag_count;
            default: avs_readdata <= 32'h0;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         ctrl <= CTRL_RESET;
         factor <= FACTOR_RESET;
         units <= UNITS_RESET;
         mrd <= MRD_RESET;
      end else if (bus_take && avs_write) begin
         unique case (avs_address)
            REG_CTRL: ctrl <= CTL_BITS'(merge_be({16'h0, ctrl}, avs_writedata,
               avs_byteenable));
            REG_FACTOR: factor <= merge_be(factor, avs_writedata, avs_byteenable);
            REG_UNITS: units <= merge_be(units, avs_writedata, avs_byteenable);
            REG_MRD: mrd <= merge_be(mrd, avs_writedata, avs_byteenable);
            default: ;
         endcase
      end
   end

   // ==========================================================
   // control decode; one mode field covers both faces
   logic [1:0] mode;
   logic is_point;
   logic is_line;
   logic is_fill;
   logic ms_on;
   logic early_on;
   assign mode = ctrl[CTL_MODE +: 2];
   assign is_point = mode == MODE_POINT;
   assign is_line = mode == MODE_LINE;
   // unused code 3 behaves as fill
   assign is_fill = !is_point && !is_line;
   assign ms_on = ctrl[CTL_MS] & ctrl[CTL_SBUF];
   assign early_on = ctrl[CTL_EARLY];

   // ==========================================================
   // culling, decided before any mode is applied
   logic [1:0] csel;
   logic culled;
   assign csel = ctrl[CTL_CSEL +: 2];
   always_comb begin
      culled = 1'b0;
      if (ctrl[CTL_CULL]) begin
         if (in_frag.front) begin
            culled = csel != CSEL_BACK;
         end else begin
            culled = csel != CSEL_FRONT;
         end
      end
   end

   // ==========================================================
   // coverage per mode; candidates arrive as points, edges or
   // area spans matching the mode
   logic aa_on;
   logic emit_cov;
   logic [NSAMP-1:0] cov_mask;
   logic [7:0] cov_val;
   logic [31:0] z_base;
   always_comb begin
      // polygon aa only in fill, point/line aa otherwise
      aa_on = is_fill ? ctrl[CTL_AA] :
         (is_point ? ctrl[CTL_PT_AA] : ctrl[CTL_LN_AA]);
      z_base = in_frag.z;
      if (ms_on) begin
         // multisample ignores every aa setting
         cov_mask = in_frag.samples;
         emit_cov = |in_frag.samples;
         cov_val = COV_FULL;
      end else if (aa_on) begin
         cov_mask = {NSAMP{1'b1}};
         emit_cov = in_frag.area_cov != 8'h0;
         cov_val = in_frag.area_cov;
         if (is_fill && in_frag.area_cov != COV_FULL) begin
            z_base = in_frag.z_area;
         end
      end else begin
         cov_mask = {NSAMP{in_frag.center_in}};
         emit_cov = in_frag.center_in;
         cov_val = COV_FULL;
      end
   end

   // ==========================================================
   // depth offset
   logic [31:0] slope;
   logic [31:0] res;
   logic signed [63:0] prod_m;
   logic signed [63:0] prod_r;
   logic signed [33:0] ofs;
   logic ofs_on;
   logic signed [33:0] z_sum;
   logic [31:0] z_out;
   // max of absolute partials stands in for the root sum
   assign slope = abs32(in_frag.dzdx) > abs32(in_frag.dzdy) ?
      abs32(in_frag.dzdx) : abs32(in_frag.dzdy);
   // no depth buffer: resolution treated as zero
   assign res = !ctrl[CTL_ZPRES] ? 32'h0 :
      (ctrl[CTL_ZFLT] ? pow2_res(in_frag.zexp) : mrd);
   assign prod_m = $signed({32'h0, slope}) * $signed(factor);
   assign prod_r = $signed({32'h0, res}) * $signed(units);
   // both terms in q16.16 of the unit depth range
   assign ofs = 34'(prod_m >>> FRAC_BITS) + 34'(prod_r >>> FRAC_BITS);
   assign ofs_on = (is_point && ctrl[CTL_OFS_PT]) ||
      (is_line && ctrl[CTL_OFS_LN]) || (is_fill && ctrl[CTL_OFS_FL]);
   assign z_sum = $signed({2'b00, z_base}) + (ofs_on ? ofs : 34'sh0);
   // clamp regardless of depth storage format
   assign z_out = z_sum < 0 ? 32'h0 :
      (z_sum > $signed({2'b00, Z_ONE}) ? Z_ONE : z_sum[31:0]);

   // ==========================================================
   // early tests in fixed order; later ones only when enabled
   logic pass_fixed;
   logic pass_early;
   logic keep;
   assign pass_fixed = in_frag.owned && in_frag.scissor_ok;
   assign pass_early = !early_on ||
      (in_frag.stencil_ok && in_frag.depth_ok);
   assign keep = !culled && emit_cov && pass_fixed && pass_early;

   // ==========================================================
   // single output stage; ready only while it is empty, which
   // halves peak rate but keeps every port on a flip-flop
   logic accept;
   logic next_full;
   assign accept = in_valid && in_ready;
   always_comb begin
      if (out_valid) begin
         next_full = !out_ready;
      end else begin
         next_full = accept && keep;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         out_valid <= 1'b0;
         in_ready <= 1'b0;
      end else begin
         out_valid <= next_full;
         in_ready <= !next_full;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         out_frag <= '0;
      end else if (accept && keep) begin
         out_frag.xy <= in_frag.xy;
         out_frag.z <= z_out;
         out_frag.cov_mask <= cov_mask;
         out_frag.cov_val <= cov_val;
         out_frag.early_done <= early_on;
         out_frag.shader_z_ignored <= early_on;
      end
   end

   // occlusion samples counted here only in early mode
   always_ff @(posedge clock) begin
      if (rst) begin
         occ_count <= 32'h0;
      end else if (accept && keep && early_on) begin
         occ_count <= occ_count + 32'(popcnt(cov_mask));
      end else if (bus_take && avs_write && avs_address == REG_OCC) begin
         occ_count <= 32'h0;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         frag_count <= 32'h0;
      end else if (accept && keep) begin
         frag_count <= frag_count + 32'h1;
      end else if (bus_take && avs_write && avs_address == REG_FRAGS) begin
         frag_count <= 32'h0;
      end
   end

   // ==========================================================
   // checks
   a_reset_state: assert property (@(posedge clock) $fell(rst) |->
      ctrl[CTL_MODE +: 2] == MODE_FILL && !ctrl[CTL_AA] && factor == 32'h0
      && units == 32'h0 && ctrl[CTL_OFS_FL:CTL_OFS_PT] == 3'h0)
      else $error("reset state wrong");
   a_cull_drop: assert property (@(posedge clock) disable iff (rst)
      accept && culled |=> !out_valid || $past(out_valid))
      else $error("culled fragment forwarded");
   a_test_drop: assert property (@(posedge clock) disable iff (rst)
      accept && (!pass_fixed || !pass_early) && !out_valid |=> !out_valid)
      else $error("failed fragment forwarded");
   a_clamp_range: assert property (@(posedge clock) disable iff (rst)
      out_valid |-> out_frag.z <= Z_ONE)
      else $error("depth outside unit range");
   a_ms_cover: assert property (@(posedge clock) disable iff (rst)
      accept && keep && ms_on |=> out_frag.cov_mask == $past(in_frag.samples))
      else $error("coverage mask mismatch");
   a_ms_full: assert property (@(posedge clock) disable iff (rst)
      accept && keep && ms_on |=> out_frag.cov_val == COV_FULL)
      else $error("multisample coverage value wrong");
   a_aa_cover: assert property (@(posedge clock) disable iff (rst)
      accept && keep && aa_on && !ms_on |=> out_frag.cov_val == $past(in_frag.area_cov))
      else $error("area coverage value wrong");
   a_area_depth: assert property (@(posedge clock) disable iff (rst)
      accept && keep && aa_on && !ms_on && is_fill && !ofs_on && in_frag.area_cov != COV_FULL
      |=> out_frag.z == $past(in_frag.z_area))
      else $error("partial square depth not area based");
   a_ofs_gate: assert property (@(posedge clock) disable iff (rst)
      accept && keep && !ofs_on && !aa_on |=> out_frag.z == $past(in_frag.z))
      else $error("offset added while disabled");
   a_early_flag: assert property (@(posedge clock) disable iff (rst)
      accept && keep |=> out_frag.shader_z_ignored == $past(early_on))
      else $error("early flag wrong");
   a_occ_count: assert property (@(posedge clock) disable iff (rst)
      accept && keep && !early_on |=> occ_count == $past(occ_count)
      || occ_count == 32'h0)
      else $error("late fragment counted early");
   a_bus_answer: assert property (@(posedge clock) disable iff (rst)
      bus_req && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("bus answer timing wrong");
   a_hold_out: assert property (@(posedge clock) disable iff (rst)
      out_valid && !out_ready |=> out_valid && $stable(out_frag))
      else $error("output dropped under stall");
endmodule : pro_raster_top

// ==== tb/pro_shade_sink.sv ====
// downstream shading stand-in that accepts fragments with random stalls
`timescale 1ns/1ps
module pro_shade_sink (
   input wire logic clock,
   input wire logic rst,
   input wire logic out_valid,
   output logic out_ready
);
   // ==========================================================
   // stall generator
   int seed = 98025;
   // stalls keep the output register full, so the input side sees back-pressure
   always @(posedge clock) begin
      if (rst) begin
         out_ready <= 1'b0;
      end else begin
         out_ready <= (($random(seed) & 3) != 0) || !out_valid;
      end
   end
endmodule : pro_shade_sink

// ==== tb/testbench.sv ====
// self-checking bench for the polygon raster option stage
`timescale 1ns/1ps
`define CHK(got, exp) chk(64'(got), 64'(exp))
module testbench
   import pro_pkg::*;
;
   typedef struct packed {
      pro_frag_out_s f;
   } pro_exp_s;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic [4:0] avs_address = '0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = '0;
   logic [3:0] avs_byteenable = 4'hF;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic in_valid = 1'b0;
   logic in_ready;
   pro_frag_in_s in_frag = '0;
   logic out_valid;
   logic out_ready;
   pro_frag_out_s out_frag;
   int fails = 0;
   int compares = 0;
   int seed = 98025;
   int factor = 0;
   int units = 0;
   int mrd = 1;
   int kept = 0;
   int occ = 0;
   logic [15:0] ctrl = CTRL_RESET;
   logic [31:0] rd;
   pro_exp_s expq[$];
   pro_exp_s mon_e;
   logic [31:0] rstv [7] = '{{16'h0, CTRL_RESET}, FACTOR_RESET, UNITS_RESET, MRD_RESET, 0, 0, 0};

   always #12.5 clock = ~clock;

   pro_raster_top dut (.clock(clock), .rst(rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .in_valid(in_valid), .in_ready(in_ready),
      .in_frag(in_frag), .out_valid(out_valid), .out_ready(out_ready), .out_frag(out_frag));
   pro_shade_sink sink (.clock(clock), .rst(rst), .out_valid(out_valid), .out_ready(out_ready));

   // ==========================================================
   // checking and closing
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic print_verdict;
      $display("counts: %0d compares, %0d fails", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : print_verdict

   task automatic timeout;
      fails++;
      $display("wrong value at %0t: handshake timed out", $time);
      print_verdict();
   endtask : timeout

   // ==========================================================
   // bus and stream drivers
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                      input logic [3:0] be);
      int n;
      @(posedge clock);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= d;
      avs_byteenable <= be;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 40);
      if (n >= 40) timeout();
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus

   // reference model of one candidate; returns whether it is forwarded
   function automatic bit model(input pro_frag_in_s f, output pro_exp_s e);
      logic [1:0] md;
      bit ms;
      bit aa;
      bit keep;
      longint m;
      longint r;
      longint z;
      md = ctrl[2:1];
      ms = ctrl[CTL_MS] && ctrl[CTL_SBUF];
      aa = !ms && (md[1] ? ctrl[CTL_AA] : md[0] ? ctrl[CTL_LN_AA] : ctrl[CTL_PT_AA]);
      keep = ms ? (f.samples != 0) : aa ? (f.area_cov != 8'h00) : f.center_in;
      keep = keep && f.owned && f.scissor_ok;
      if (ctrl[CTL_EARLY]) keep = keep && f.stencil_ok && f.depth_ok;
      if (ctrl[CTL_CULL] && ctrl[8:7] != (f.front ? CSEL_BACK : CSEL_FRONT)) keep = 0;
      m = longint'(f.dzdx);
      if (m < 0) m = -m;
      r = longint'(f.dzdy);
      if (r < 0) r = -r;
      if (r > m) m = r;
      if (!ctrl[CTL_ZPRES]) r = 0;
      else if (ctrl[CTL_ZFLT]) r = 64'sd1 <<< (f.zexp - 7);
      else r = mrd;
      z = (aa && md[1] && f.area_cov != COV_FULL) ? f.z_area : f.z;
      if (ctrl[CTL_OFS_PT + (md[1] ? 2 : int'(md))]) z += (m * factor + r * units) >>> 16;
      if (z < 0) z = 0;
      if (z > Z_ONE) z = Z_ONE;
      e = '0;
      e.f.xy = f.xy;
      e.f.z = 32'(z);
      e.f.cov_mask = ms ? f.samples : {NSAMP{1'b1}};
      e.f.cov_val = (ms || !aa) ? COV_FULL : f.area_cov;
      e.f.early_done = ctrl[CTL_EARLY];
      e.f.shader_z_ignored = ctrl[CTL_EARLY];
      return keep;
   endfunction : model

   task automatic send(input pro_frag_in_s f);
      int n;
      pro_exp_s e;
      @(posedge clock);
      in_valid <= 1'b1;
      in_frag <= f;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (in_ready !== 1'b1 && n < 40);
      if (n >= 40) timeout();
      in_valid <= 1'b0;
      if (model(f, e)) begin
         expq.push_back(e);
         kept++;
         if (ctrl[CTL_EARLY]) occ += $countones(e.f.cov_mask);
      end
   endtask : send

   function automatic pro_frag_in_s rnd_frag();
      pro_frag_in_s f;
      f.xy = $random(seed);
      f.front = 1'($random(seed));
      f.z = 32'($random(seed) & 32'hFFFF);
      f.z_area = 32'($random(seed) & 32'hFFFF);
      f.dzdx = $random(seed) % 16384;
      f.dzdy = $random(seed) % 16384;
      f.zexp = 8'(($random(seed) & 15) + 7);
      f.samples = 4'($random(seed));
      f.center_in = 1'($random(seed));
      f.area_cov = 8'h55 * 8'($random(seed) & 3);
      f.owned = ($random(seed) & 7) != 0;
      f.scissor_ok = ($random(seed) & 7) != 0;
      f.stencil_ok = ($random(seed) & 3) != 0;
      f.depth_ok = ($random(seed) & 3) != 0;
      return f;
   endfunction : rnd_frag

   // ==========================================================
   // output monitor
   always @(posedge clock) begin
      if (!rst && out_valid === 1'b1 && out_ready === 1'b1) begin
         if (expq.size() == 0) begin
            `CHK(1'b1, 1'b0);
         end else begin
            mon_e = expq.pop_front();
            `CHK(out_frag.xy, mon_e.f.xy);
            `CHK(out_frag.z, mon_e.f.z);
            `CHK(out_frag.cov_mask, mon_e.f.cov_mask);
            `CHK(out_frag.cov_val, mon_e.f.cov_val);
            `CHK(out_frag.early_done, mon_e.f.early_done);
            `CHK(out_frag.shader_z_ignored, mon_e.f.shader_z_ignored);
         end
      end
   end

   // ==========================================================
   // main sequence
   initial begin
      int n;
      repeat (12) @(posedge clock);
      rst <= 1'b0;
      for (int i = 0; i < 7; i++) begin
         bus(1'b0, 5'(i * 4), 32'h0, 4'hF);
         `CHK(rd, rstv[i]);
      end
      bus(1'b1, REG_FACTOR, 32'hFFFFFFAB, 4'h1);
      bus(1'b0, REG_FACTOR, 32'h0, 4'hF);
      `CHK(rd, 32'h000000AB);
      for (int b = 0; b < 24; b++) begin
         if (b > 0) begin
            ctrl = 16'($random(seed));
            if (ctrl[8:7] == 2'h3) ctrl[8:7] = CSEL_BOTH;
            factor = ($random(seed) % 4) * 65536;
            units = ($random(seed) % 4) * 65536;
            mrd = ($random(seed) & 255) + 1;
         end
         // one mode field serves both orientations
         bus(1'b1, REG_CTRL, {16'h0, ctrl}, 4'hF);
         bus(1'b1, REG_FACTOR, factor, 4'hF);
         bus(1'b1, REG_UNITS, units, 4'hF);
         bus(1'b1, REG_MRD, mrd, 4'hF);
         for (int k = 0; k < 16; k++) send(rnd_frag());
         n = 0;
         while (expq.size() != 0 && n < 100) begin
            @(posedge clock);
            n++;
         end
         if (n >= 100) timeout();
      end
      bus(1'b0, REG_FRAGS, 32'h0, 4'hF);
      `CHK(rd, kept);
      bus(1'b0, REG_OCC, 32'h0, 4'hF);
      `CHK(rd, occ);
      bus(1'b1, REG_OCC, 32'h0, 4'hF);
      bus(1'b1, REG_FRAGS, 32'h0, 4'hF);
      bus(1'b0, REG_OCC, 32'h0, 4'hF);
      `CHK(rd, 32'h0);
      bus(1'b0, REG_FRAGS, 32'h0, 4'hF);
      `CHK(rd, 32'h0);
      print_verdict();
   end
endmodule : testbench
